/* File: rtl/acrm_pkg.sv */
// Package with opcodes, register map and shared types of the accumulator move decoder.
package acrm_pkg;
  localparam int ACC_W = 4;
  localparam int OP_W = 10;
  localparam logic [OP_W-1:0] OP_LOAD_PULLUP_2 = 10'h22F;
  localparam logic [OP_W-1:0] OP_LOAD_CONVERTER_CONTROL = 10'h204;
  localparam logic [OP_W-1:0] OP_LOAD_CLOCK_BIT = 10'h209;
  localparam logic [OP_W-1:0] OP_LOAD_SERIAL_BUFFER = 10'h238;
  localparam logic [OP_W-1:0] OP_LOAD_IRQ_CONTROL_1 = 10'h03F;
  localparam logic [OP_W-1:0] OP_LOAD_IRQ_CONTROL_2 = 10'h03E;
  localparam logic [OP_W-1:0] OP_LOAD_TIMER_CONTROL_1 = 10'h20E;
  localparam logic [OP_W-1:0] OP_LOAD_TIMER_CONTROL_2 = 10'h20F;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PULLUP_2 = 8'h08;
  localparam logic [7:0] ADDR_CONVERTER = 8'h0C;
  localparam logic [7:0] ADDR_CLOCK_BIT = 8'h10;
  localparam logic [7:0] ADDR_SERIAL = 8'h14;
  localparam logic [7:0] ADDR_IRQ_1 = 8'h18;
  localparam logic [7:0] ADDR_IRQ_2 = 8'h1C;
  localparam logic [7:0] ADDR_TIMER_1 = 8'h20;
  localparam logic [7:0] ADDR_TIMER_2 = 8'h24;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam int STATUS_HIT_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [ACC_W-1:0] CTL_RST = 4'h0;

  typedef struct packed {
    logic [ACC_W-1:0] pullup_control_2;
    logic [ACC_W-1:0] converter_control;
    logic clock_control_bit;
    logic [2*ACC_W-1:0] serial_buffer;
    logic [ACC_W-1:0] irq_control_1;
    logic [ACC_W-1:0] irq_control_2;
    logic [ACC_W-1:0] timer_control_1;
    logic [ACC_W-1:0] timer_control_2;
  } acrm_ctl_t;
endpackage

/* File: rtl/acrm_dest_reg.sv */
// One destination control register loaded by a decoded move.
`timescale 1ns/10ps
module acrm_dest_reg #(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] q_d;
  logic [WIDTH-1:0] q_q;

  // Checked while the design is built, so a bad width never reaches simulation.
  if (WIDTH < 1) begin : g_width_check
    $error("acrm_dest_reg: WIDTH must be at least 1.");
  end

  always_comb begin
    q_d = q_q;
    if (load) begin
      q_d = din;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q_q <= '0;
    end else if (clk_en) begin
      q_q <= q_d;
    end
  end

  assign q = q_q;
endmodule

/* File: rtl/acrm_decoder.sv */
// Decoder and executor for accumulator to control register moves, with an AXI4-Lite register view.
`timescale 1ns/10ps
// Function
// - Opcode 22F copies the whole accumulator into pull-up control register 2 in one cycle.
// - Opcode 204 copies the accumulator into the converter control register in one cycle.
// - Opcode 209 copies only accumulator bit 0 into the clock control bit in one cycle.
// - Opcode 238 loads the serial buffer high nibble from B and low nibble from the accumulator together.
// - Opcode 03F copies the accumulator into interrupt control register 1 in one cycle.
// - Opcode 03E copies the accumulator into interrupt control register 2 in one cycle.
// - Opcode 20E copies the accumulator into timer control register 1 in one cycle.
// - Opcode 20F copies the accumulator into timer control register 2 in one cycle.
module acrm_decoder
  import acrm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [OP_W-1:0] instr_word,
  input wire logic [ACC_W-1:0] acc,
  input wire logic [ACC_W-1:0] reg_b,
  output acrm_ctl_t ctl,
  output logic exec_hit,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_addr_w_check
    $error("acrm_decoder: ADDR_W must lie between 6 and 8.");
  end

  logic enable_q;
  logic enable_d;
  logic [OP_W-1:0] last_op_q;
  logic [OP_W-1:0] last_op_d;
  logic hit_q;
  logic hit_d;
  logic go;
  logic ld_pu2;
  logic ld_conv;
  logic ld_clk;
  logic ld_ser;
  logic ld_irq1;
  logic ld_irq2;
  logic ld_tmr1;
  logic ld_tmr2;
  logic any_hit;

  // Decode is purely combinational so every move finishes in the cycle that presents it.
  assign go = clk_en & instr_valid & enable_q;
  assign ld_pu2 = go & (instr_word == OP_LOAD_PULLUP_2);
  assign ld_conv = go & (instr_word == OP_LOAD_CONVERTER_CONTROL);
  assign ld_clk = go & (instr_word == OP_LOAD_CLOCK_BIT);
  assign ld_ser = go & (instr_word == OP_LOAD_SERIAL_BUFFER);
  assign ld_irq1 = go & (instr_word == OP_LOAD_IRQ_CONTROL_1);
  assign ld_irq2 = go & (instr_word == OP_LOAD_IRQ_CONTROL_2);
  assign ld_tmr1 = go & (instr_word == OP_LOAD_TIMER_CONTROL_1);
  assign ld_tmr2 = go & (instr_word == OP_LOAD_TIMER_CONTROL_2);
  // There is no path back to carry, accumulator or program counter, so no skip can arise.
  assign any_hit = ld_pu2 | ld_conv | ld_clk | ld_ser | ld_irq1 | ld_irq2 | ld_tmr1 | ld_tmr2;

  acrm_dest_reg #(.WIDTH(ACC_W)) u_pu2 (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .load(ld_pu2), .din(acc), .q(ctl.pullup_control_2)
  );
  acrm_dest_reg #(.WIDTH(ACC_W)) u_conv (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .load(ld_conv), .din(acc), .q(ctl.converter_control)
  );
  acrm_dest_reg #(.WIDTH(1)) u_clk (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .load(ld_clk), .din(acc[0]), .q(ctl.clock_control_bit)
  );
  acrm_dest_reg #(.WIDTH(2*ACC_W)) u_ser (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .load(ld_ser), .din({reg_b, acc}), .q(ctl.serial_buffer)
  );
  acrm_dest_reg #(.WIDTH(ACC_W)) u_irq1 (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .load(ld_irq1), .din(acc), .q(ctl.irq_control_1)
  );
  acrm_dest_reg #(.WIDTH(ACC_W)) u_irq2 (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .load(ld_irq2), .din(acc), .q(ctl.irq_control_2)
  );
  acrm_dest_reg #(.WIDTH(ACC_W)) u_tmr1 (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .load(ld_tmr1), .din(acc), .q(ctl.timer_control_1)
  );
  acrm_dest_reg #(.WIDTH(ACC_W)) u_tmr2 (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .load(ld_tmr2), .din(acc), .q(ctl.timer_control_2)
  );

  // Write channel state.
  logic aw_have_q;
  logic aw_have_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] aw_addr_d;
  logic w_have_q;
  logic w_have_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0] w_strb_q;
  logic [3:0] w_strb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic aw_fire;
  logic w_fire;
  logic wr_do;
  logic [7:0] wr_addr;

  assign s_axi_awready = clk_en & ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = clk_en & ~w_have_q & ~bvalid_q;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign wr_do = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_addr = 8'(aw_addr_q);

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    enable_d = enable_q;
    if (aw_fire) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (w_fire) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_do) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_SLVERR;
      if (wr_addr == ADDR_CTRL) begin
        bresp_d = RESP_OKAY;
        if (w_strb_q[0]) begin
          enable_d = w_data_q[CTRL_ENABLE_BIT];
        end
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      enable_q <= CTRL_ENABLE_RST;
    end else if (clk_en) begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      enable_q <= enable_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel and decoder status.
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic ar_fire;
  logic [7:0] rd_addr;

  assign s_axi_arready = clk_en & ~rvalid_q;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign rd_addr = 8'(s_axi_araddr);

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    last_op_d = last_op_q;
    hit_d = any_hit;
    if (any_hit) begin
      last_op_d = instr_word;
    end
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (rd_addr)
        ADDR_CTRL: rdata_d[CTRL_ENABLE_BIT] = enable_q;
        ADDR_STATUS: rdata_d = {15'h0000, hit_q, 6'h00, last_op_q};
        ADDR_PULLUP_2: rdata_d[ACC_W-1:0] = ctl.pullup_control_2;
        ADDR_CONVERTER: rdata_d[ACC_W-1:0] = ctl.converter_control;
        ADDR_CLOCK_BIT: rdata_d[0] = ctl.clock_control_bit;
        ADDR_SERIAL: rdata_d[2*ACC_W-1:0] = ctl.serial_buffer;
        ADDR_IRQ_1: rdata_d[ACC_W-1:0] = ctl.irq_control_1;
        ADDR_IRQ_2: rdata_d[ACC_W-1:0] = ctl.irq_control_2;
        ADDR_TIMER_1: rdata_d[ACC_W-1:0] = ctl.timer_control_1;
        ADDR_TIMER_2: rdata_d[ACC_W-1:0] = ctl.timer_control_2;
        default: rresp_d = RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      last_op_q <= '0;
      hit_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      last_op_q <= last_op_d;
      hit_q <= hit_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign exec_hit = hit_q;
endmodule

/* File: bench/acrm_prog_rom.sv */
// Program memory model that hands instruction words to the decoder.
`timescale 1ns/10ps
module acrm_prog_rom
  import acrm_pkg::*;
(
  input wire logic [3:0] pc,
  input wire logic fetch,
  output logic [OP_W-1:0] word
);
  localparam logic [OP_W-1:0] ROM [11] = '{OP_LOAD_PULLUP_2, OP_LOAD_CONVERTER_CONTROL, OP_LOAD_CLOCK_BIT,
    OP_LOAD_SERIAL_BUFFER, OP_LOAD_IRQ_CONTROL_1, OP_LOAD_IRQ_CONTROL_2, OP_LOAD_TIMER_CONTROL_1,
    OP_LOAD_TIMER_CONTROL_2, 10'h22E, 10'h000, 10'h3FF};
  // Between fetches the word is inverted, so that a stale opcode never passes for a fresh one.
  assign word = fetch ? ROM[pc] : ~ROM[pc];
endmodule

/* File: bench/acrm_decoder_props.sv */
// Checker on the decoder ports.
`timescale 1ns/10ps
module acrm_props
  import acrm_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [OP_W-1:0] instr_word,
  input wire logic [ACC_W-1:0] acc,
  input wire logic [ACC_W-1:0] reg_b,
  input wire acrm_ctl_t ctl,
  input wire logic exec_hit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_mv(logic [OP_W-1:0] op);
    instr_valid && clk_en && instr_word == op;
  endsequence
  property p_pu;
    s_mv(OP_LOAD_PULLUP_2) |=> exec_hit ? ctl.pullup_control_2 == $past(acc) : $stable(ctl);
  endproperty
  a_pu: assert property (p_pu) else $error("pu2");
  property p_cv;
    s_mv(OP_LOAD_CONVERTER_CONTROL) |=> exec_hit ? ctl.converter_control == $past(acc) : $stable(ctl);
  endproperty
  a_cv: assert property (p_cv) else $error("conv");
  property p_ck;
    s_mv(OP_LOAD_CLOCK_BIT) |=> exec_hit ? ctl.clock_control_bit == $past(acc[0]) : $stable(ctl);
  endproperty
  a_ck: assert property (p_ck) else $error("clk");
  property p_sb;
    s_mv(OP_LOAD_SERIAL_BUFFER) |=> exec_hit ? ctl.serial_buffer == $past({reg_b, acc}) : $stable(ctl);
  endproperty
  a_sb: assert property (p_sb) else $error("ser");
  property p_i1;
    s_mv(OP_LOAD_IRQ_CONTROL_1) |=> exec_hit ? ctl.irq_control_1 == $past(acc) : $stable(ctl);
  endproperty
  a_i1: assert property (p_i1) else $error("irq1");
  property p_i2;
    s_mv(OP_LOAD_IRQ_CONTROL_2) |=> exec_hit ? ctl.irq_control_2 == $past(acc) : $stable(ctl);
  endproperty
  a_i2: assert property (p_i2) else $error("irq2");
  property p_t1;
    s_mv(OP_LOAD_TIMER_CONTROL_1) |=> exec_hit ? ctl.timer_control_1 == $past(acc) : $stable(ctl);
  endproperty
  a_t1: assert property (p_t1) else $error("tmr1");
  property p_t2;
    s_mv(OP_LOAD_TIMER_CONTROL_2) |=> exec_hit ? ctl.timer_control_2 == $past(acc) : $stable(ctl);
  endproperty
  a_t2: assert property (p_t2) else $error("tmr2");
  property p_only;
    !$stable(ctl) && !$past(srst) |-> exec_hit;
  endproperty
  a_only: assert property (p_only) else $error("stray");
  property p_hit;
    exec_hit && $past(clk_en) |-> $past(instr_valid);
  endproperty
  a_hit: assert property (p_hit) else $error("hit");
endmodule
bind acrm_decoder acrm_props i_props (.mclk(mclk), .srst(srst), .clk_en(clk_en), .instr_valid(instr_valid),
  .instr_word(instr_word), .acc(acc), .reg_b(reg_b), .ctl(ctl), .exec_hit(exec_hit));

/* File: bench/test_acrm_decoder.sv */
// Self-checking bench for the accumulator move decoder.
`timescale 1ns/10ps
module test_acrm_decoder;
  import acrm_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, clk_en = 1'b1, instr_valid = 1'b0, exec_hit, ctrl_en = 1'b1, hit_q = 1'b0;
  logic [3:0] pc = 4'h0, acc = 4'h0, reg_b = 4'h0;
  logic [OP_W-1:0] instr_word;
  acrm_ctl_t ctl, exp_ctl = '0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0, checks_done = 0, cyc = 0;
  initial forever #10 mclk = ~mclk;
  acrm_prog_rom i_rom (.pc, .fetch(instr_valid), .word(instr_word));
  acrm_decoder i_dut (.mclk, .srst, .clk_en, .instr_valid, .instr_word, .acc, .reg_b, .ctl, .exec_hit,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic check(input logic [63:0] got, input logic [63:0] want);
    checks_done++;
    if (got !== want) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, da = 1'b0, dw = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge mclk);
      ta = s_axi_awready & !da;
      tw = s_axi_wready & !dw;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end while (!(da && dw));
    s_axi_bready <= 1'b1;
    do @(negedge mclk); while (!s_axi_bvalid);
    check(s_axi_bresp, r);
    @(posedge mclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge mclk); while (!s_axi_arready);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge mclk); while (!s_axi_rvalid);
    check(s_axi_rdata, d);
    check(s_axi_rresp, r);
    @(posedge mclk);
    s_axi_rready <= 1'b0;
  endtask
  // Each call judges the move offered by the call before it, so moves run back to back.
  task automatic step(input logic [3:0] p, input logic v, e, input logic [3:0] a, b);
    @(posedge mclk);
    pc <= p;
    instr_valid <= v;
    clk_en <= e;
    acc <= a;
    reg_b <= b;
    @(negedge mclk);
    check(exec_hit, hit_q);
    check(ctl, exp_ctl);
    if (e) hit_q = v && ctrl_en && p < 8;
    if (e && hit_q) case (p)
      0: exp_ctl.pullup_control_2 = a;
      1: exp_ctl.converter_control = a;
      2: exp_ctl.clock_control_bit = a[0];
      3: exp_ctl.serial_buffer = {b, a};
      4: exp_ctl.irq_control_1 = a;
      5: exp_ctl.irq_control_2 = a;
      6: exp_ctl.timer_control_1 = a;
      default: exp_ctl.timer_control_2 = a;
    endcase
  endtask
  task automatic idle();
    step(4'h0, 1'b0, 1'b1, 4'h0, 4'h0);
  endtask
  task automatic t_reset();
    @(negedge mclk);
    check(ctl, 64'h0);
    axi_rd(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
  endtask
  task automatic t_moves();
    for (int i = 0; i < 8; i++) step(4'(i), 1'b1, 1'b1, 4'(15 - i), 4'(i + 1));
    step(4'h2, 1'b1, 1'b1, 4'hA, 4'h7);
    idle();
  endtask
  task automatic t_refuse();
    for (int i = 8; i < 11; i++) step(4'(i), 1'b1, 1'b1, 4'h5, 4'h5);
    step(4'h1, 1'b0, 1'b1, 4'h5, 4'h5);
    step(4'h1, 1'b1, 1'b0, 4'h3, 4'h3);
    idle();
    axi_wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    ctrl_en = 1'b0;
    step(4'h3, 1'b1, 1'b1, 4'h1, 4'h1);
    idle();
    axi_wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    ctrl_en = 1'b1;
    // Without byte lane 0 the enable bit must keep its value.
    s_axi_wstrb <= 4'hE;
    axi_wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
  endtask
  task automatic t_regs();
    step(4'h4, 1'b1, 1'b1, 4'h9, 4'h0);
    idle();
    axi_rd(ADDR_IRQ_1, 32'h0000_0009, RESP_OKAY);
    axi_rd(ADDR_SERIAL, 32'h0000_004C, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h0000_003F, RESP_OKAY);
    axi_rd(8'h28, 32'h0000_0000, RESP_SLVERR);
    axi_wr(ADDR_PULLUP_2, 32'h0000_0001, RESP_SLVERR);
    axi_rd(ADDR_PULLUP_2, 32'h0000_000F, RESP_OKAY);
  endtask
  task automatic t_rereset();
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    exp_ctl = '0;
    idle();
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_moves();
    t_refuse();
    t_regs();
    t_rereset();
    conclude();
  end
endmodule
